// *** verification/gpc_pad_model.sv ***
// gpc_pad_model: outside parts on the pads.
// assumes undriven pads float.
module gpc_pad_model (
  input wire logic [7:0] pin_out, // drive level
  input wire logic [7:0] pin_oe, // drive enable
  input wire logic [7:0] pin_pu, // pull-up
  input wire logic [7:0] ext_oe, // outside enable
  input wire logic [7:0] ext_lvl, // outside level
  output logic [7:0] pad // pad level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating pad is high when pulled up, otherwise it shows the inverse of the outside level
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_lvl) | (~pin_oe & ~ext_oe & (pin_pu | ~ext_lvl));
endmodule : gpc_pad_model

// *** verification/gpc_port_monitor.sv ***
// gpc_port_monitor: assertions on the port block.
// assumes a bind to gpc_port.
module gpc_port_monitor #(
  parameter int PORT_W = 8
) (
  input wire logic REF_CLK, // clock
  input wire logic NRST, // reset
  input wire logic PSEL, // select
  input wire logic PENABLE, // access
  input wire logic PWRITE, // write
  input wire logic [gpc_pkg::ADDR_W-1:0] PADDR, // address
  input wire logic [gpc_pkg::DATA_W-1:0] PWDATA, // data
  input wire logic [3:0] PSTRB, // strobes
  input wire logic PREADY, // ready
  input wire logic PSLVERR, // error
  input wire logic [PORT_W-1:0] PIN_OUT, // level
  input wire logic [PORT_W-1:0] PIN_OE, // enable
  input wire logic [PORT_W-1:0] PIN_PULLUP // pull-up
);
  logic [PORT_W-1:0] wlo;
  logic wr;
  assign wlo = PWDATA[PORT_W-1:0];
  assign wr = PSEL & PENABLE & PREADY & PWRITE & PSTRB[0] & ~PSLVERR;
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  AST_PU: assert property ((PIN_PULLUP & (PIN_OE | ~PIN_OUT)) == '0) else $error("pull-up");
  AST_RST: assert property (disable iff (1'b0) !NRST |-> PIN_OE == '0 && PIN_PULLUP == '0)
    else $error("reset pins");
  AST_TGL: assert property (wr && PADDR == gpc_pkg::OFS_PIN_INPUT |=> PIN_OUT == ($past(PIN_OUT) ^ $past(wlo)))
    else $error("toggle");
  AST_OUT: assert property (wr && PADDR == gpc_pkg::OFS_OUTPUT_DATA |=> PIN_OUT == $past(wlo))
    else $error("out");
  AST_DIR: assert property (wr && PADDR == gpc_pkg::OFS_DIRECTION |=> PIN_OE == $past(wlo)) else $error("dir");
  AST_HOLD: assert property (!wr |=> $stable(PIN_OUT) && $stable(PIN_OE)) else $error("hold");
  AST_WAIT: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY) else $error("wait");
  AST_PULSE: assert property (PREADY |=> !PREADY) else $error("pulse");
  cover property (wr && PADDR == gpc_pkg::OFS_PIN_INPUT);
  cover property (PREADY && PSLVERR);
  cover property (PIN_PULLUP != '0);
endmodule : gpc_port_monitor

bind gpc_port gpc_port_monitor #(.PORT_W(PORT_W)) mon_inst (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP));

// *** verification/gpc_port_test.sv ***
// gpc_port_test: directed bench for the port block.
// assumes the pad model on the pins.
module gpc_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0;
  logic pready, slverr, err;
  logic [7:0] paddr = 8'h00, ext_oe = 8'h00, ext_lvl = 8'h00;
  logic [7:0] p_out, p_oe, p_pu, pad, flag, rd;
  logic [31:0] wdata = 32'h0, prdata;
  int mismatches = 0, total_checks = 0;
  gpc_port gpc_port_inst (.REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(wdata), .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata), .PSLVERR(slverr),
    .PIN_IN(pad), .PIN_OUT(p_out), .PIN_OE(p_oe), .PIN_PULLUP(p_pu), .SLEEP_DEEP(sleep), .EXT_FLAG(flag));
  gpc_pad_model gpc_pad_model_inst (.pin_out(p_out), .pin_oe(p_oe), .pin_pu(p_pu), .ext_oe(ext_oe),
    .ext_lvl(ext_lvl), .pad(pad));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    wdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // look at ready where it has settled, complete on the following rising edge
    n = 0;
    @(negedge ref_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    rd = prdata[7:0];
    err = slverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      mismatches++;
      conclude();
    end
  endtask : apb
  task automatic t_reset();
    apb(1'b1, gpc_pkg::OFS_OUTPUT_DATA, 8'hff);
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(negedge ref_clk);
    chk(p_pu, 8'h00);
    chk(p_oe, 8'h00);
    @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, gpc_pkg::OFS_OUTPUT_DATA, 8'h00);
    chk(rd, 8'h00);
    apb(1'b0, gpc_pkg::OFS_DIRECTION, 8'h00);
    chk(rd, 8'h00);
    apb(1'b0, 8'h1c, 8'h00);
    chk({7'h00, err}, 8'h01);
    $display("reset test done");
  endtask : t_reset
  task automatic t_modes();
    logic dir, out;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, i[0] ? gpc_pkg::OFS_DIRECTION : gpc_pkg::OFS_OUTPUT_DATA, i < 2 ? 8'hff : 8'h00);
      dir = i == 1 || i == 2;
      out = i < 2;
      @(negedge ref_clk);
      chk(p_oe, {8{dir}});
      chk(p_out, {8{out}});
      chk(p_pu, {8{~dir & out}});
    end
    apb(1'b1, gpc_pkg::OFS_OUTPUT_DATA, 8'hff);
    apb(1'b1, gpc_pkg::OFS_MCU_CONTROL, 8'h10);
    @(negedge ref_clk);
    chk(p_pu, 8'h00);
    apb(1'b1, gpc_pkg::OFS_MCU_CONTROL, 8'h00);
    $display("mode test done");
  endtask : t_modes
  task automatic t_toggle();
    apb(1'b1, gpc_pkg::OFS_PIN_INPUT, 8'h0f);
    apb(1'b1, gpc_pkg::OFS_PIN_INPUT, 8'h00);
    apb(1'b1, gpc_pkg::OFS_DIRECTION, 8'hff);
    apb(1'b1, gpc_pkg::OFS_PIN_INPUT, 8'h81);
    @(negedge ref_clk);
    chk(p_out, 8'h71);
    $display("toggle test done");
  endtask : t_toggle
  task automatic t_read();
    apb(1'b1, gpc_pkg::OFS_OUTPUT_DATA, 8'ha5);
    apb(1'b0, gpc_pkg::OFS_PIN_INPUT, 8'h00);
    chk(rd, 8'ha5);
    ext_oe <= 8'h0f;
    ext_lvl <= 8'hf3;
    apb(1'b1, gpc_pkg::OFS_DIRECTION, 8'h00);
    apb(1'b0, gpc_pkg::OFS_PIN_INPUT, 8'h00);
    chk(rd, 8'ha3);
    $display("read test done");
  endtask : t_read
  task automatic t_sleep();
    ext_oe <= 8'hff;
    ext_lvl <= 8'hff;
    apb(1'b1, gpc_pkg::OFS_EXT_SENSE, 8'hf0);
    apb(1'b1, gpc_pkg::OFS_EXT_ENABLE, 8'h0f);
    @(posedge ref_clk);
    sleep <= 1'b1;
    apb(1'b0, gpc_pkg::OFS_PIN_INPUT, 8'h00);
    chk(rd, 8'h0f);
    apb(1'b1, gpc_pkg::OFS_EXT_FLAG, 8'hff);
    @(posedge ref_clk);
    sleep <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(flag, 8'hf0);
    $display("sleep test done");
  endtask : t_sleep
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_modes();
    t_toggle();
    t_read();
    t_sleep();
    conclude();
  end
endmodule : gpc_port_test

// *** verilog/gpc_pkg.sv ***
// gpc_pkg: register map, reset values and bus constants of the port block.
// assumes a 32-bit APB slave port with one aligned word per register.
package gpc_pkg;

  // documented width of one port
  localparam int PORT_W = 8;

  // apb data width
  localparam int DATA_W = 32;

  // apb address width seen by the block
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_PIN_INPUT = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_DATA = 8'h04;
  localparam logic [7:0] OFS_DIRECTION = 8'h08;
  localparam logic [7:0] OFS_MCU_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_EXT_ENABLE = 8'h10;
  localparam logic [7:0] OFS_EXT_SENSE = 8'h14;
  localparam logic [7:0] OFS_EXT_FLAG = 8'h18;

  // field position of the global pull-up disable in the control register
  localparam int POS_PULLUP_DISABLE_ALL = 4;

  // reset values
  localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_EXT_ENABLE = 8'h00;
  localparam logic [7:0] RST_EXT_SENSE = 8'h00;
  localparam logic [7:0] RST_EXT_FLAG = 8'h00;
  localparam logic RST_PULLUP_DISABLE_ALL = 1'b0;

  // wait states inserted by the slave before pready
  localparam int APB_WAIT_CYCLES = 1;

  // register selector
  typedef enum logic [2:0] {
    GPC_SEL_PIN_INPUT = 3'h0,
    GPC_SEL_OUTPUT_DATA = 3'h1,
    GPC_SEL_DIRECTION = 3'h3,
    GPC_SEL_MCU_CONTROL = 3'h2,
    GPC_SEL_EXT_ENABLE = 3'h6,
    GPC_SEL_EXT_SENSE = 3'h7,
    GPC_SEL_EXT_FLAG = 3'h5,
    GPC_SEL_NONE = 3'h4
  } gpc_sel_t;

  // one apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] strb;
  } gpc_apb_req_t;

endpackage : gpc_pkg

// *** verilog/gpc_port.sv ***
// gpc_port: one general-purpose i/o port with apb register access.
// assumes the pad wire is resolved outside from PIN_OUT, PIN_OE and PIN_PULLUP,
// and that SLEEP_DEEP comes from the sleep controller on the same clock.
//
// Overview of operation
// - writing one to a pin input bit inverts the output data bit; zero does nothing.
// - pull-up on only with direction 0, output data 1 and global disable 0.
// - global pull-up disable turns every pull-up off, inputs become high impedance.
// - direction 1 drives the pin to the output data level, pull-up off.
// - pin input register shows the synchronized pin level in any direction, except clamped pins in deep sleep.
// - synchronizer is a clock-high transparent latch then a rising-edge register.
// - a written output value reaches the pin input register one clock later.
// - in deep sleep the digital input is clamped to ground before the trigger.
// - clamp skips pins whose external interrupt is enabled, applies when disabled.
// - a high sensing pin with interrupt disabled sets its flag on waking.
// - pull-ups stay disabled during reset.
// - reset tri-states all pins at once, without a clock.
// - three port locations: output data, direction, and pin input, where a write toggles output data.
module gpc_port #(
  parameter int PORT_W = gpc_pkg::PORT_W
) (
  input wire logic REF_CLK, // 100 mhz system clock
  input wire logic NRST, // asynchronous reset
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction, 1 = write
  input wire logic [gpc_pkg::ADDR_W-1:0] PADDR, // apb byte address
  input wire logic [gpc_pkg::DATA_W-1:0] PWDATA, // apb write data
  input wire logic [3:0] PSTRB, // apb byte strobes
  output logic PREADY, // apb ready
  output logic [gpc_pkg::DATA_W-1:0] PRDATA, // apb read data
  output logic PSLVERR, // apb error on unmapped address
  input wire logic [PORT_W-1:0] PIN_IN, // pad level, input side
  output logic [PORT_W-1:0] PIN_OUT, // pad drive level
  output logic [PORT_W-1:0] PIN_OE, // pad driver enable
  output logic [PORT_W-1:0] PIN_PULLUP, // pad pull-up enable
  input wire logic SLEEP_DEEP, // deep sleep clamp request
  output logic [PORT_W-1:0] EXT_FLAG // external interrupt flags
);

  typedef struct packed {
    logic [PORT_W-1:0] out_data;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] ext_en;
    logic [PORT_W-1:0] ext_sense;
    logic [PORT_W-1:0] ext_flag;
    logic [PORT_W-1:0] pin_sync;
    logic [PORT_W-1:0] pin_prev;
    logic pullup_disable_all;
    logic ack;
    logic err;
    logic [gpc_pkg::DATA_W-1:0] rdata;
  } gpc_state_t;

  gpc_state_t st_r;
  gpc_state_t st_nxt;
  gpc_pkg::gpc_apb_req_t req;
  gpc_pkg::gpc_sel_t sel;
  logic [PORT_W-1:0] pad_level;
  logic [PORT_W-1:0] clamp;
  logic [PORT_W-1:0] din;
  logic [PORT_W-1:0] sync_latch;
  logic [PORT_W-1:0] wbyte;
  logic do_write;

  // address decode, shared by the read and write paths
  function automatic gpc_pkg::gpc_sel_t decode(input logic [gpc_pkg::ADDR_W-1:0] addr);
    gpc_pkg::gpc_sel_t s;
    s = gpc_pkg::GPC_SEL_NONE;
    unique case (addr)
      gpc_pkg::OFS_PIN_INPUT: s = gpc_pkg::GPC_SEL_PIN_INPUT;
      gpc_pkg::OFS_OUTPUT_DATA: s = gpc_pkg::GPC_SEL_OUTPUT_DATA;
      gpc_pkg::OFS_DIRECTION: s = gpc_pkg::GPC_SEL_DIRECTION;
      gpc_pkg::OFS_MCU_CONTROL: s = gpc_pkg::GPC_SEL_MCU_CONTROL;
      gpc_pkg::OFS_EXT_ENABLE: s = gpc_pkg::GPC_SEL_EXT_ENABLE;
      gpc_pkg::OFS_EXT_SENSE: s = gpc_pkg::GPC_SEL_EXT_SENSE;
      gpc_pkg::OFS_EXT_FLAG: s = gpc_pkg::GPC_SEL_EXT_FLAG;
      default: s = gpc_pkg::GPC_SEL_NONE;
    endcase
    return s;
  endfunction : decode

  // zero-extend a port-wide value to the bus width
  function automatic logic [gpc_pkg::DATA_W-1:0] zext(input logic [PORT_W-1:0] v);
    logic [gpc_pkg::DATA_W-1:0] r;
    r = '0;
    r[PORT_W-1:0] = v;
    return r;
  endfunction : zext

  // pull-up decode of one port from direction, output data and global disable
  function automatic logic [PORT_W-1:0] pullup_of(input logic [PORT_W-1:0] d, input logic [PORT_W-1:0] o,
                                                  input logic pullup_disable_all);
    return ~d & o & {PORT_W{~pullup_disable_all}};
  endfunction : pullup_of

  assign req.sel = PSEL;
  assign req.enable = PENABLE;
  assign req.write = PWRITE;
  assign req.addr = PADDR;
  assign req.wdata = PWDATA;
  assign req.strb = PSTRB;

  assign sel = decode(req.addr);
  assign wbyte = req.wdata[PORT_W-1:0];

  // a write takes effect only at the edge that completes the access
  assign do_write = req.sel & req.enable & st_r.ack & req.write & req.strb[0];

  // the pad shows the driven value while the driver is on
  assign pad_level = (st_r.dir & st_r.out_data) | (~st_r.dir & PIN_IN);

  // clamp in deep sleep, except on pins with the external interrupt enabled
  assign clamp = {PORT_W{SLEEP_DEEP}} & ~st_r.ext_en;
  assign din = pad_level & ~clamp;

  // first synchronizer stage: open while the clock is high, holds when it falls
  always_latch begin
    if (!NRST) begin
      sync_latch <= '0;
    end else if (REF_CLK) begin
      sync_latch <= din;
    end
  end

  always_comb begin
    st_nxt = st_r;

    // second synchronizer stage loads the latch on the rising edge
    st_nxt.pin_sync = sync_latch;
    st_nxt.pin_prev = st_r.pin_sync;

    // change on a sensing pin sets its flag; releasing the clamp counts as one
    st_nxt.ext_flag = st_r.ext_flag;
    if (do_write && sel == gpc_pkg::GPC_SEL_EXT_FLAG) begin
      st_nxt.ext_flag = st_r.ext_flag & ~wbyte;
    end
    st_nxt.ext_flag = st_nxt.ext_flag | (st_r.ext_sense & (st_r.pin_sync ^ st_r.pin_prev));

    // apb: one wait state, read data captured at the same edge where pready rises
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    if (req.sel && req.enable && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.err = (sel == gpc_pkg::GPC_SEL_NONE);
      st_nxt.rdata = '0;
      unique case (sel)
        gpc_pkg::GPC_SEL_PIN_INPUT: st_nxt.rdata = zext(st_r.pin_sync);
        gpc_pkg::GPC_SEL_OUTPUT_DATA: st_nxt.rdata = zext(st_r.out_data);
        gpc_pkg::GPC_SEL_DIRECTION: st_nxt.rdata = zext(st_r.dir);
        gpc_pkg::GPC_SEL_MCU_CONTROL: st_nxt.rdata[gpc_pkg::POS_PULLUP_DISABLE_ALL] = st_r.pullup_disable_all;
        gpc_pkg::GPC_SEL_EXT_ENABLE: st_nxt.rdata = zext(st_r.ext_en);
        gpc_pkg::GPC_SEL_EXT_SENSE: st_nxt.rdata = zext(st_r.ext_sense);
        gpc_pkg::GPC_SEL_EXT_FLAG: st_nxt.rdata = zext(st_r.ext_flag);
        gpc_pkg::GPC_SEL_NONE: st_nxt.rdata = '0;
      endcase
    end

    if (do_write) begin
      unique case (sel)
        gpc_pkg::GPC_SEL_PIN_INPUT: st_nxt.out_data = st_r.out_data ^ wbyte;
        gpc_pkg::GPC_SEL_OUTPUT_DATA: st_nxt.out_data = wbyte;
        gpc_pkg::GPC_SEL_DIRECTION: st_nxt.dir = wbyte;
        gpc_pkg::GPC_SEL_MCU_CONTROL: st_nxt.pullup_disable_all = req.wdata[gpc_pkg::POS_PULLUP_DISABLE_ALL];
        gpc_pkg::GPC_SEL_EXT_ENABLE: st_nxt.ext_en = wbyte;
        gpc_pkg::GPC_SEL_EXT_SENSE: st_nxt.ext_sense = wbyte;
        gpc_pkg::GPC_SEL_EXT_FLAG: st_nxt.ext_flag = st_nxt.ext_flag;
        gpc_pkg::GPC_SEL_NONE: st_nxt.ext_flag = st_nxt.ext_flag;
      endcase
    end
  end

  // asynchronous reset clears drive and pull-up state at once, clock or not
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r.out_data <= gpc_pkg::RST_OUTPUT_DATA[PORT_W-1:0];
      st_r.dir <= gpc_pkg::RST_DIRECTION[PORT_W-1:0];
      st_r.ext_en <= gpc_pkg::RST_EXT_ENABLE[PORT_W-1:0];
      st_r.ext_sense <= gpc_pkg::RST_EXT_SENSE[PORT_W-1:0];
      st_r.ext_flag <= gpc_pkg::RST_EXT_FLAG[PORT_W-1:0];
      st_r.pin_sync <= '0;
      st_r.pin_prev <= '0;
      st_r.pullup_disable_all <= gpc_pkg::RST_PULLUP_DISABLE_ALL;
      st_r.ack <= 1'b0;
      st_r.err <= 1'b0;
      st_r.rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PREADY = req.sel & req.enable & st_r.ack;
  assign PSLVERR = PREADY & st_r.err;
  assign PRDATA = st_r.rdata;

  assign PIN_OUT = st_r.out_data;
  assign PIN_OE = st_r.dir;
  assign PIN_PULLUP = pullup_of(st_r.dir, st_r.out_data, st_r.pullup_disable_all);
  assign EXT_FLAG = st_r.ext_flag;

endmodule : gpc_port
